// File: inc/ulf_params.svh
// Constants of the serial port: register indices, reset values, codes, counts.
// Assumes inclusion by bare name from the top module ulf_uart only.
`ifndef ULF_PARAMS_SVH
`define ULF_PARAMS_SVH
// Register indices; byte address is four times the index
`define ULF_IDX_DATA 4'h0
`define ULF_IDX_IER 4'h1
`define ULF_IDX_IIR 4'h2
`define ULF_IDX_LCR 4'h3
`define ULF_IDX_LSR 4'h5
`define ULF_IDX_MSR 4'h6
`define ULF_IDX_ISTS 4'h8
`define ULF_IDX_IMSK 4'h9
// Reset values
`define ULF_LCR_RST 8'h00
`define ULF_DIV_RST 16'h0010
`define ULF_IER_RST 4'h0
`define ULF_EVT_RST 5'h00
// Source codes reported in the identification register
`define ULF_ID_LINE 3'h3
`define ULF_ID_RDA 3'h2
`define ULF_ID_TO 3'h6
`define ULF_ID_THRE 3'h1
`define ULF_ID_MDM 3'h0
// Receive trigger levels in bytes
`define ULF_TRIG_1 5'h01
`define ULF_TRIG_4 5'h04
`define ULF_TRIG_8 5'h08
`define ULF_TRIG_14 5'h0e
// Queue depth and idle timeout in character times
`define ULF_Q_DEPTH 5'h10
`define ULF_TO_CHARS 7'h04
`endif

// File: inc/ulf_pkg.sv
// Types shared by the serial port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ulf_pkg;
  typedef struct packed
  {
    logic divisor_window_select;
    logic brk;
    logic stick;
    logic even;
    logic pen;
    logic stop;
    logic [1:0] wlen;
  } ulf_lcr_t;

  typedef struct packed
  {
    logic [7:0] data;
    logic perr;
    logic ferr;
    logic brk;
  } ulf_rx_res_t;

  typedef enum logic [2:0]
  {
    ULF_IDLE = 3'b000,
    ULF_START = 3'b001,
    ULF_DATA = 3'b010,
    ULF_PAR = 3'b011,
    ULF_STOP = 3'b100
  } ulf_fr_st_t;
endpackage

// File: src/ulf_rx.sv
// Serial receiver: finds a start edge, samples mid-bit, checks parity and stop.
// Assumes the line input is already synchronous to the clock.
`timescale 1ns/1ps
module ulf_rx
  import ulf_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Configuration
  input wire ulf_lcr_t i_lcr,
  input wire logic [15:0] i_div,
  // Line
  input wire logic i_rxd,
  // Result
  output logic o_done,
  output ulf_rx_res_t o_res
);
  ulf_fr_st_t st_reg;
  logic [15:0] tmr_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shf_reg;
  logic ones_reg;
  logic perr_reg;
  logic any_reg;
  logic prev_reg;
  logic [15:0] full;
  logic [15:0] half;
  logic tick;
  logic [3:0] nbits;
  logic expect_par;

  assign full = (i_div == 16'h0) ? 16'h0001 : i_div;
  assign half = (i_div[15:1] == 15'h0) ? 16'h0001 : {1'b0, i_div[15:1]};
  assign tick = (tmr_reg == 16'h0001);
  assign nbits = 4'h5 + {2'h0, i_lcr.wlen};
  assign expect_par = i_lcr.stick ? !i_lcr.even : (i_lcr.even ? ones_reg : !ones_reg);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_reg <= ULF_IDLE;
      tmr_reg <= 16'h0001;
      cnt_reg <= 4'h0;
      shf_reg <= 8'h00;
      ones_reg <= 1'b0;
      perr_reg <= 1'b0;
      any_reg <= 1'b0;
      prev_reg <= 1'b1;
      o_done <= 1'b0;
      o_res <= '0;
    end
    else
    begin
      prev_reg <= i_rxd;
      o_done <= 1'b0;
      if (st_reg == ULF_IDLE)
      begin
        tmr_reg <= half;
        cnt_reg <= 4'h0;
        ones_reg <= 1'b0;
        perr_reg <= 1'b0;
        any_reg <= 1'b0;
        if (prev_reg && !i_rxd)
          st_reg <= ULF_START;
      end
      else
      begin
        tmr_reg <= tick ? full : tmr_reg - 16'h0001;
        if (tick)
        begin
          unique case (st_reg)
            ULF_START:
              // A start that is high again at mid-bit was a glitch
              st_reg <= i_rxd ? ULF_IDLE : ULF_DATA;
            ULF_DATA:
            begin
              shf_reg <= {i_rxd, shf_reg[7:1]};
              ones_reg <= ones_reg ^ i_rxd;
              any_reg <= any_reg | i_rxd;
              cnt_reg <= cnt_reg + 4'h1;
              if (cnt_reg == nbits - 4'h1)
                st_reg <= i_lcr.pen ? ULF_PAR : ULF_STOP;
            end
            ULF_PAR:
            begin
              perr_reg <= (i_rxd != expect_par);
              any_reg <= any_reg | i_rxd;
              st_reg <= ULF_STOP;
            end
            ULF_STOP:
            begin
              // Only the first stop is sampled; the rest look like idle line
              st_reg <= ULF_IDLE;
              o_done <= 1'b1;
              o_res.data <= shf_reg >> (4'h8 - nbits);
              o_res.perr <= perr_reg;
              o_res.ferr <= !i_rxd;
              o_res.brk <= !i_rxd && !any_reg;
            end
            default:
              st_reg <= ULF_IDLE;
          endcase
        end
      end
    end
  end
endmodule // ulf_rx

// File: src/ulf_tx.sv
// Serial transmitter: frames one character from a load strobe.
// Assumes load only while not busy; the caller forces break on the line.
`timescale 1ns/1ps
module ulf_tx
  import ulf_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Configuration
  input wire ulf_lcr_t i_lcr,
  input wire logic [15:0] i_div,
  // Holding register side
  input wire logic i_load,
  input wire logic [7:0] i_data,
  output logic o_busy,
  // Line
  output logic o_line
);
  ulf_fr_st_t st_reg;
  logic [15:0] tmr_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shf_reg;
  logic par_reg;
  logic [15:0] half;
  logic tick;
  logic [3:0] nbits;
  logic [3:0] stop_halves;
  logic ones;

  // Time is kept in half bits so that 1.5 stop bits needs no second timer
  assign half = (i_div[15:1] == 15'h0) ? 16'h0001 : {1'b0, i_div[15:1]};
  assign tick = (tmr_reg == 16'h0001);
  assign nbits = 4'h5 + {2'h0, i_lcr.wlen};
  assign stop_halves = !i_lcr.stop ? 4'h2 : ((i_lcr.wlen == 2'h0) ? 4'h3 : 4'h4);
  assign ones = ^(i_data & (8'hff >> (4'h8 - nbits)));
  assign o_busy = (st_reg != ULF_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_reg <= ULF_IDLE;
      tmr_reg <= 16'h0001;
      cnt_reg <= 4'h0;
      shf_reg <= 8'h00;
      par_reg <= 1'b0;
    end
    else if (st_reg == ULF_IDLE)
    begin
      tmr_reg <= half;
      cnt_reg <= 4'h0;
      if (i_load)
      begin
        st_reg <= ULF_START;
        shf_reg <= i_data;
        // Stick forces the inverse of even select; otherwise odd or even sum
        par_reg <= i_lcr.stick ? !i_lcr.even : (i_lcr.even ? ones : !ones);
      end
    end
    else
    begin
      tmr_reg <= tick ? half : tmr_reg - 16'h0001;
      if (tick)
      begin
        cnt_reg <= cnt_reg + 4'h1;
        unique case (st_reg)
          ULF_START:
            if (cnt_reg == 4'h1)
            begin
              st_reg <= ULF_DATA;
              cnt_reg <= 4'h0;
            end
          ULF_DATA:
            if (cnt_reg[0])
            begin
              shf_reg <= {1'b0, shf_reg[7:1]};
              if (cnt_reg[3:1] == 3'(nbits - 4'h1))
              begin
                st_reg <= i_lcr.pen ? ULF_PAR : ULF_STOP;
                cnt_reg <= 4'h0;
              end
            end
          ULF_PAR:
            if (cnt_reg == 4'h1)
            begin
              st_reg <= ULF_STOP;
              cnt_reg <= 4'h0;
            end
          ULF_STOP:
            if (cnt_reg == stop_halves - 4'h1)
              st_reg <= ULF_IDLE;
          default:
            st_reg <= ULF_IDLE;
        endcase
      end
    end
  end

  always_comb
  begin
    unique case (st_reg)
      ULF_START: o_line = 1'b0;
      ULF_DATA: o_line = shf_reg[0];
      ULF_PAR: o_line = par_reg;
      default: o_line = 1'b1;
    endcase
  end
endmodule // ulf_tx

// File: src/ulf_uart.sv
// Serial port top: APB registers, receive queue, interrupt identification.
// Assumes an APB master on i_ref_clk and a line input synchronous to it.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "ulf_params.svh"

module ulf_uart
  import ulf_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial line and modem event
  input wire logic i_rxd,
  input wire logic i_modem_evt,
  output logic o_txd,
  // Interrupt
  output logic o_irq
);
  ulf_lcr_t lcr_reg;
  logic [3:0] ier_reg;
  logic [7:0] dll_reg;
  logic [7:0] dlm_reg;
  logic fifo_en_reg;
  logic [1:0] trig_reg;
  logic [4:0] ists_reg;
  logic [4:0] imsk_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [2:0] iid_snap_reg;
  logic [7:0] q_mem [16];
  logic [3:0] wptr_reg;
  logic [3:0] rptr_reg;
  logic [4:0] q_cnt_reg;
  logic oe_reg;
  logic pe_reg;
  logic fe_reg;
  logic bi_reg;
  logic [7:0] thr_reg;
  logic thr_full_reg;
  logic thre_pend_reg;
  logic mdm_pend_reg;
  logic to_pend_reg;
  logic [15:0] bit_tmr_reg;
  logic [6:0] to_cnt_reg;
  logic txd_reg;
  logic irq_reg;
  logic [3:0] idx;
  logic setup;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic divisor_window_select;
  logic [15:0] div;
  logic [7:0] rd_val;
  logic [2:0] iid_code;
  logic irq_none_pending_n_n;
  logic tx_busy;
  logic tx_line;
  logic tx_load;
  logic rx_done;
  ulf_rx_res_t rx_res;
  logic [4:0] q_cap;
  logic q_full;
  logic q_clr;
  logic push;
  logic pop;
  logic [4:0] trig_lvl;
  logic rda;
  logic lsr_pend;
  logic [3:0] char_bits;
  logic [6:0] to_limit;
  logic to_hit;
  logic bit_tick;
  logic [4:0] evt;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; every access completes one cycle after its setup
  assign idx = i_paddr[5:2];
  assign setup = i_psel && !i_penable;
  // Unmapped accesses are refused: no write lands and no read side effect
  assign wr_done = i_psel && i_penable && pready_reg && i_pwrite && mapped;
  assign rd_done = i_psel && i_penable && pready_reg && !i_pwrite && mapped;
  assign divisor_window_select = lcr_reg.divisor_window_select;
  assign div = {dlm_reg, dll_reg};
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_txd = txd_reg;
  assign o_irq = irq_reg;

  always_comb
  begin
    mapped = (i_paddr[7:6] == 2'h0) && (i_paddr[1:0] == 2'h0);
    unique case (idx)
      `ULF_IDX_DATA: rd_val = divisor_window_select ? dll_reg : q_mem[rptr_reg];
      `ULF_IDX_IER: rd_val = divisor_window_select ? dlm_reg : {4'h0, ier_reg};
      `ULF_IDX_IIR: rd_val = {fifo_en_reg, fifo_en_reg, 2'h0, iid_code, irq_none_pending_n_n};
      `ULF_IDX_LCR: rd_val = lcr_reg;
      `ULF_IDX_LSR: rd_val = {fifo_en_reg && (pe_reg || fe_reg || bi_reg),
                              !thr_full_reg && !tx_busy, !thr_full_reg,
                              bi_reg, fe_reg, pe_reg, oe_reg, q_cnt_reg != 5'h0};
      `ULF_IDX_MSR: rd_val = {7'h0, mdm_pend_reg};
      `ULF_IDX_ISTS: rd_val = {3'h0, ists_reg};
      `ULF_IDX_IMSK: rd_val = {3'h0, imsk_reg};
      default:
      begin
        rd_val = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // Read data is captured at setup, so the reported source cannot move
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
      iid_snap_reg <= 3'h0;
    end
    else
    begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup)
      begin
        prdata_reg <= mapped ? {24'h0, rd_val} : 32'h0;
        iid_snap_reg <= irq_none_pending_n_n ? 3'h7 : iid_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      lcr_reg <= `ULF_LCR_RST;
      ier_reg <= `ULF_IER_RST;
      {dlm_reg, dll_reg} <= `ULF_DIV_RST;
      fifo_en_reg <= 1'b0;
      trig_reg <= 2'h0;
      imsk_reg <= `ULF_EVT_RST;
    end
    else if (wr_done)
    begin
      unique case (idx)
        `ULF_IDX_DATA: if (divisor_window_select) dll_reg <= i_pwdata[7:0];
        `ULF_IDX_IER:
          if (divisor_window_select)
            dlm_reg <= i_pwdata[7:0];
          else
            ier_reg <= i_pwdata[3:0];
        `ULF_IDX_IIR:
        begin
          fifo_en_reg <= i_pwdata[0];
          trig_reg <= i_pwdata[7:6];
        end
        `ULF_IDX_LCR: lcr_reg <= i_pwdata[7:0];
        `ULF_IDX_IMSK: imsk_reg <= i_pwdata[4:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path
  assign tx_load = thr_full_reg && !tx_busy;

  ulf_tx u_tx
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_lcr(lcr_reg),
    .i_div(div),
    .i_load(tx_load),
    .i_data(thr_reg),
    .o_busy(tx_busy),
    .o_line(tx_line)
  );

  // A write in the cycle the holder empties refills it, so empty must not show
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      thr_reg <= 8'h00;
      thr_full_reg <= 1'b0;
      thre_pend_reg <= 1'b0;
    end
    else
    begin
      if (tx_load)
      begin
        thr_full_reg <= 1'b0;
        thre_pend_reg <= 1'b1;
      end
      else if (rd_done && idx == `ULF_IDX_IIR && iid_snap_reg == `ULF_ID_THRE)
        thre_pend_reg <= 1'b0;
      if (wr_done && idx == `ULF_IDX_IIR && i_pwdata[2])
        thr_full_reg <= 1'b0;
      if (wr_done && idx == `ULF_IDX_DATA && !divisor_window_select)
      begin
        thr_reg <= i_pwdata[7:0];
        thr_full_reg <= 1'b1;
        thre_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      txd_reg <= 1'b1;
    else
      txd_reg <= lcr_reg.brk ? 1'b0 : tx_line;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path and queue; without FIFO mode the queue holds one byte
  ulf_rx u_rx
  (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_lcr(lcr_reg),
    .i_div(div),
    .i_rxd(i_rxd),
    .o_done(rx_done),
    .o_res(rx_res)
  );

  assign q_cap = fifo_en_reg ? `ULF_Q_DEPTH : 5'h01;
  assign q_full = (q_cnt_reg == q_cap);
  assign q_clr = wr_done && idx == `ULF_IDX_IIR && (i_pwdata[1] || i_pwdata[0] != fifo_en_reg);
  assign push = rx_done && !q_full;
  assign pop = rd_done && idx == `ULF_IDX_DATA && !divisor_window_select && q_cnt_reg != 5'h0;

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
      q_mem[wptr_reg] <= rx_res.data;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || q_clr)
    begin
      wptr_reg <= 4'h0;
      rptr_reg <= 4'h0;
      q_cnt_reg <= 5'h0;
    end
    else
    begin
      if (push)
        wptr_reg <= wptr_reg + 4'h1;
      if (pop)
        rptr_reg <= rptr_reg + 4'h1;
      if (push && !pop)
        q_cnt_reg <= q_cnt_reg + 5'h1;
      else if (pop && !push)
        q_cnt_reg <= q_cnt_reg - 5'h1;
    end
  end

  // Error flags: a new error in the read cycle survives the clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      {oe_reg, pe_reg, fe_reg, bi_reg} <= 4'h0;
    else
    begin
      if (rd_done && idx == `ULF_IDX_LSR)
        {oe_reg, pe_reg, fe_reg, bi_reg} <= 4'h0;
      if (rx_done)
      begin
        if (q_full)
          oe_reg <= 1'b1;
        if (rx_res.perr)
          pe_reg <= 1'b1;
        if (rx_res.ferr)
          fe_reg <= 1'b1;
        if (rx_res.brk)
          bi_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character timeout, counted in bit times of the current frame format
  always_comb
  begin
    unique case (trig_reg)
      2'h0: trig_lvl = `ULF_TRIG_1;
      2'h1: trig_lvl = `ULF_TRIG_4;
      2'h2: trig_lvl = `ULF_TRIG_8;
      2'h3: trig_lvl = `ULF_TRIG_14;
    endcase
  end

  assign rda = fifo_en_reg ? (q_cnt_reg >= trig_lvl) : (q_cnt_reg != 5'h0);
  assign char_bits = 4'h7 + {2'h0, lcr_reg.wlen} + {3'h0, lcr_reg.pen} + {3'h0, lcr_reg.stop};
  assign to_limit = 7'(`ULF_TO_CHARS * {3'h0, char_bits});
  assign to_hit = fifo_en_reg && q_cnt_reg != 5'h0 && to_cnt_reg == to_limit;
  assign bit_tick = (bit_tmr_reg <= 16'h0001);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      bit_tmr_reg <= 16'h0001;
      to_cnt_reg <= 7'h0;
      to_pend_reg <= 1'b0;
    end
    else
    begin
      bit_tmr_reg <= bit_tick ? div : bit_tmr_reg - 16'h0001;
      if (!fifo_en_reg || q_cnt_reg == 5'h0 || push || pop)
        to_cnt_reg <= 7'h0;
      else if (bit_tick && !to_hit)
        to_cnt_reg <= to_cnt_reg + 7'h1;
      if (pop || q_clr)
        to_pend_reg <= 1'b0;
      else if (to_hit)
        to_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      mdm_pend_reg <= 1'b0;
    else if (i_modem_evt)
      mdm_pend_reg <= 1'b1;
    else if (rd_done && idx == `ULF_IDX_MSR)
      mdm_pend_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Identification: a single source by fixed priority
  assign lsr_pend = oe_reg || pe_reg || fe_reg || bi_reg;

  always_comb
  begin
    irq_none_pending_n_n = 1'b0;
    if (ier_reg[2] && lsr_pend)
      iid_code = `ULF_ID_LINE;
    else if (ier_reg[0] && rda)
      iid_code = `ULF_ID_RDA;
    else if (ier_reg[0] && to_pend_reg)
      iid_code = `ULF_ID_TO;
    else if (ier_reg[1] && thre_pend_reg)
      iid_code = `ULF_ID_THRE;
    else if (ier_reg[3] && mdm_pend_reg)
      iid_code = `ULF_ID_MDM;
    else
    begin
      iid_code = 3'h0;
      irq_none_pending_n_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event status, write one to clear; a new event beats the clear
  assign evt = {i_modem_evt, to_hit && !to_pend_reg, tx_load, push,
                rx_done && (q_full || rx_res.perr || rx_res.ferr || rx_res.brk)};

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ists_reg <= `ULF_EVT_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wr_done && idx == `ULF_IDX_ISTS)
        ists_reg <= (ists_reg & ~i_pwdata[4:0]) | evt;
      else
        ists_reg <= ists_reg | evt;
      irq_reg <= |(ists_reg & imsk_reg);
    end
  end
endmodule // ulf_uart

// File: test/testbench.sv
// Testbench of the serial port: APB master, remote peer, frame format table.
// Assumes divisor 8 is set through the divisor window before traffic.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic mev = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic prdy, perr, erv, rxd, txd, irq;
  logic [11:0] b, e;
  logic [7:0] dm;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int len, n, p;
  logic [7:0] lc [8] = '{8'h03, 8'h00, 8'h04, 8'h0d, 8'h1a, 8'h2b, 8'h3b, 8'h0f};
  logic [7:0] dv [8] = '{8'ha5, 8'h1f, 8'h13, 8'h2c, 8'h5b, 8'h96, 8'h96, 8'h01};
  int lv [8] = '{80, 56, 60, 80, 80, 88, 88, 96};
  ulf_uart DUT (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(prdy), .o_pslverr(perr), .i_rxd(rxd), .i_modem_evt(mev),
    .o_txd(txd), .o_irq(irq));
  ulf_remote #(.DIV(8)) u_peer (.i_ref_clk(clk), .i_txd(txd), .o_rxd(rxd));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic ck(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'h0, a, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rdv = prdata;
    erv = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(0, 4'h2, 0);
    ck(rdv, 32'h01);
    apb(0, 4'h3, 0);
    ck(rdv, 32'h00);
    apb(0, 4'h4, 0);
    ck({rdv[30:0], erv}, 32'h1);
    apb(1, 4'h3, 32'h80);
    apb(1, 4'h0, 32'h08);
    apb(1, 4'h1, 32'h00);
    apb(0, 4'h0, 0);
    ck(rdv, 32'h08);
    apb(1, 4'h3, 32'h03);
    apb(1, 4'h1, 32'h0f);
    apb(0, 4'h1, 0);
    ck(rdv, 32'h0f);
    for (int r = 0; r < 8; r++)
    begin
      apb(1, 4'h3, {24'h0, lc[r]});
      n = 5 + lc[r][1:0];
      p = lc[r][3];
      dm = dv[r] & 8'((1 << n) - 1);
      e = 12'h0;
      for (int i = 0; i < n; i++)
        e[i + 1] = dm[i];
      if (p == 1)
        e[n + 1] = lc[r][5] ? ~lc[r][4] : ^dm ^ ~lc[r][4];
      e[n + p + 1] = 1'b1;
      fork
        u_peer.grab(n + p + 2, b, len);
        begin
          apb(1, 4'h0, {24'h0, dv[r]});
          apb(1, 4'h0, 32'h0);
        end
      join
      ck({20'h0, b}, {20'h0, e});
      ck({20'h0, b}, {20'h0, e});
      ck(32'(len >= lv[r] && len <= lv[r] + 2), 32'h1);
      repeat (120) @(posedge clk);
    end
    apb(1, 4'h0, 32'hff);
    apb(1, 4'h3, 32'h43);
    repeat (3) @(posedge clk);
    ck({31'h0, txd}, 32'h0);
    apb(1, 4'h3, 32'h03);
    repeat (120) @(posedge clk);
    ck({31'h0, txd}, 32'h1);
    apb(1, 4'h8, 32'h1f);
    apb(1, 4'h9, 32'h04);
    apb(1, 4'h0, 32'h55);
    repeat (4) @(posedge clk);
    ck({31'h0, irq}, 32'h1);
    apb(1, 4'h8, 32'h04);
    repeat (2) @(posedge clk);
    ck({31'h0, irq}, 32'h0);
    apb(1, 4'h9, 32'h00);
    apb(1, 4'h2, 32'h41);
    apb(1, 4'h3, 32'h0f);
    u_peer.send({2'h3, 8'h3c, 1'b0}, 11);
    u_peer.send({2'h3, 8'h81, 1'b0}, 11);
    repeat (450) @(posedge clk);
    apb(0, 4'h2, 0);
    ck(rdv, 32'hcc);
    apb(0, 4'h5, 0);
    ck(rdv & 32'h0e, 32'h0);
    apb(0, 4'h0, 0);
    ck(rdv, 32'h3c);
    apb(0, 4'h0, 0);
    ck(rdv, 32'h81);
    u_peer.send({2'h3, 8'h01, 1'b0}, 11);
    repeat (20) @(posedge clk);
    apb(0, 4'h2, 0);
    ck(rdv, 32'hc6);
    apb(0, 4'h5, 0);
    ck(rdv & 32'h04, 32'h04);
    apb(0, 4'h0, 0);
    apb(0, 4'h2, 0);
    ck(rdv, 32'hc2);
    apb(0, 4'h2, 0);
    ck(rdv, 32'hc1);
    mev <= 1'b1;
    @(posedge clk);
    mev <= 1'b0;
    repeat (2) @(posedge clk);
    apb(0, 4'h2, 0);
    ck(rdv, 32'hc0);
    apb(0, 4'h6, 0);
    apb(0, 4'h2, 0);
    ck(rdv, 32'hc1);
    finish_test();
  end
endmodule // testbench

// File: test/ulf_remote.sv
// Remote serial peer: sends frames on the receive line, captures transmit ones.
// Assumes DIV clocks per bit, as programmed in the divisor.
`timescale 1ns/1ps
module ulf_remote
#(
  parameter int DIV = 8
)
(
  // Clock
  input wire logic i_ref_clk,
  // Line
  input wire logic i_txd,
  output logic o_rxd
);
  initial o_rxd = 1'b1;
  // Bits LSB first from start; one stop only, extra stops are optional
  task automatic send(input logic [10:0] b, input int n);
    for (int i = 0; i < n; i++)
      repeat (DIV) @(posedge i_ref_clk) o_rxd <= b[i];
  endtask
  // Samples mid-bit; len is the count from one start edge to the next
  task automatic grab(input int n, output logic [11:0] b, output int len);
    int k;
    b = 12'h0;
    k = 0;
    while (i_txd !== 1'b0)
      @(posedge i_ref_clk);
    for (int i = 0; i < n; i++)
    begin
      while (k < i * DIV + DIV / 2)
      begin
        @(posedge i_ref_clk);
        k++;
      end
      b[i] = i_txd;
    end
    while (i_txd !== 1'b0)
    begin
      @(posedge i_ref_clk);
      k++;
    end
    len = k;
  endtask
endmodule // ulf_remote

// File: test/ulf_uart_assertions.sv
// Checker of the serial port top: APB timing, format readback, break, mask.
// Assumes binding to ulf_uart; mirrors line format and mask from APB writes.
`timescale 1ns/1ps
module ulf_uart_checker
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Line and interrupt
  input wire logic i_rxd,
  input wire logic i_modem_evt,
  input wire logic o_txd,
  input wire logic o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] lcr_reg;
  logic [4:0] msk_reg;
  logic wr_hit;
  logic bad;
  assign wr_hit = i_psel && i_penable && o_pready && i_pwrite;
  assign bad = (i_paddr[7:6] != 2'h0) || (i_paddr[1:0] != 2'h0) ||
    (i_paddr[5:2] == 4'h4) || (i_paddr[5:2] == 4'h7) || (i_paddr[5:2] > 4'h9);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      lcr_reg <= 8'h00;
    else if (wr_hit && i_paddr == 8'h0c)
      lcr_reg <= i_pwdata[7:0];
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      msk_reg <= 5'h00;
    else if (wr_hit && i_paddr == 8'h24)
      msk_reg <= i_pwdata[4:0];
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_done;
    i_psel && i_penable && o_pready;
  endsequence
  a_ready_next: assert property (s_setup |=> o_pready) else $error("pready late");
  a_ready_single: assert property (o_pready |=> !o_pready) else $error("pready long");
  a_upper_zero: assert property (s_done |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits");
  a_unmapped_err: assert property (s_done |-> o_pslverr == bad) else $error("pslverr");
  a_unmapped_zero: assert property (s_done ##0 (!i_pwrite && bad) |-> o_prdata == 32'h0)
    else $error("unmapped data");
  a_format_readback: assert property (s_done ##0 (!i_pwrite && i_paddr == 8'h0c)
    |-> o_prdata[7:0] == lcr_reg) else $error("format readback");
  a_break_low: assert property (lcr_reg[6] && $past(lcr_reg[6]) |-> !o_txd)
    else $error("break not low");
  a_mask_quiet: assert property (msk_reg == 5'h0 && $past(msk_reg) == 5'h0 |-> !o_irq)
    else $error("masked irq");
  a_reset_idle: assert property ($fell(i_rst) |-> o_txd && !o_irq) else $error("reset idle");
endmodule // ulf_uart_checker

bind ulf_uart ulf_uart_checker u_chk (.*);
